// ---- mcr_pkg.sv ----
/*
 * Package for the message-signaled interrupt capability registers:
 * configuration offsets, field positions, reset values and carrier types.
 * Assumes a config-space port that presents dword-aligned accesses.
 */
package mcr_pkg;

    // ========================================================
    // Register offsets (byte addresses in configuration space)
    localparam logic [7:0] MCR_OFF_CTRL_DW   = 8'h70; // id, next, control
    localparam logic [7:0] MCR_OFF_ADDR_LO   = 8'h74;
    localparam logic [7:0] MCR_OFF_ADDR_HI   = 8'h78;
    localparam logic [7:0] MCR_OFF_PAYLOAD   = 8'h7C;

    // ========================================================
    // Field positions of the control word (upper half of dword 70h)
    localparam int MCR_CTRL_SHIFT   = 16;
    localparam int MCR_BIT_ENABLE   = 0;
    localparam int MCR_REQ_LO       = 1;
    localparam int MCR_GRANT_LO     = 4;
    localparam int MCR_GRANT_HI     = 6;
    localparam int MCR_BIT_WIDECAP  = 7;
    localparam int MCR_ADDR_LO_BIT  = 2;

    // ========================================================
    // Reset and constant values
    localparam logic [15:0] MCR_CTRL_RESET     = 16'h0080;
    localparam logic [31:0] MCR_ADDR_RESET     = 32'h0000_0000;
    localparam logic [15:0] MCR_PAYLOAD_RESET  = 16'h0000;
    localparam logic [2:0]  MCR_REQ_COUNT      = 3'h0;
    localparam logic [2:0]  MCR_GRANT_RESET    = 3'h0;
    localparam logic [2:0]  MCR_GRANT_MAX      = 3'h5;
    localparam logic [7:0]  MCR_CAP_ID         = 8'h05;
    localparam logic [7:0]  MCR_NEXT_PTR       = 8'h80;
    localparam logic [1:0]  MCR_ADDR_RSVD      = 2'h0;
    localparam logic [7:0]  MCR_CTRL_RSVD      = 8'h00;

    // ========================================================
    // Configuration access carrier
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } mcr_cfg_req_s;

    // Outgoing posted memory write
    typedef struct packed {
        logic        valid;
        logic        wide;     // 64-bit address form
        logic [63:0] addr;
        logic [15:0] payload;
    } mcr_msg_s;

    // Whole module state
    typedef struct packed {
        logic        enable;
        logic [2:0]  grant;
        logic [29:0] addr_lo;
        logic [31:0] addr_hi;
        logic [15:0] payload;
        logic [31:0] rdata;
        logic        rvalid;
        mcr_msg_s    fixed_payload_bits;
    } mcr_state_s;

endpackage : mcr_pkg

// ---- mcr_msi_regs.sv ----
/*
 * Message-signaled interrupt capability registers of the upstream port.
 * Holds control, 64-bit target address and payload, and builds the posted
 * write that is sent upstream when an interrupt event arrives.
 * Assumes config accesses are one-cycle strobes and the link accepts a
 * message whenever msg_out.valid pulses (no back-pressure here).
 */
`timescale 1ns/10ps

// Overview of operation
// - The wide-address capability flag in the control word always reads one.
// - Software writes a three-bit granted message count which is stored.
// - The requested message count field always reads 000.
// - No message is sent while the signaling enable bit is zero.
// - Lower address bits 31:2 are writable and hold the message target.
// - Control bits 15:8 and lower address bits 1:0 read zero, writes ignored.
// - The upper address register is fully writable, 32 bits.
// - A zero upper address gives a 32-bit write, else a 64-bit write.
// - An enabled event sends a write of the payload to the target address.
// - Payload bits 15:4 are sent exactly as programmed.
// - Payload bits 3:0 are sent unchanged, with no vector substituted.
// - Lower address, upper address and payload reset to zero.
// - The control word resets to 0080h.
module mcr_msi_regs
    import mcr_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire mcr_pkg::mcr_cfg_req_s cfg_req,
    output logic [31:0]                cfg_rdata,
    output logic                       cfg_rvalid,
    input  wire logic                  irq_event,
    output mcr_pkg::mcr_msg_s          msg_out,
    output logic                       signaling_enabled,
    output logic [2:0]                 granted_message_count
);
    import mcr_pkg::*;

    mcr_state_s st_r;
    mcr_state_s st_nxt;
    logic [15:0] ctrl_word;
    logic [31:0] addr_lo_word;

    // ========================================================
    // Read views of mixed-access registers
    always_comb
    begin
        ctrl_word = {MCR_CTRL_RSVD, MCR_CTRL_RESET[MCR_BIT_WIDECAP],
                     st_r.grant, MCR_REQ_COUNT,
                     st_r.enable};
        addr_lo_word = {st_r.addr_lo, MCR_ADDR_RSVD};
    end

    // ========================================================
    // Next-state logic: config writes, reads and message launch
    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.rvalid    = cfg_req.rd;
        st_nxt.fixed_payload_bits.valid = 1'b0;
        // Only writable bits are taken; read-only bits have no storage
        if (cfg_req.wr)
        begin
            case (cfg_req.addr)
                MCR_OFF_CTRL_DW:
                begin
                    if (cfg_req.be[2])
                    begin
                        st_nxt.enable = cfg_req.wdata[MCR_CTRL_SHIFT
                                        + MCR_BIT_ENABLE];
                        st_nxt.grant = cfg_req.wdata[MCR_CTRL_SHIFT
                                        + MCR_GRANT_HI -: 3];
                    end
                end
                MCR_OFF_ADDR_LO:
                begin
                    if (cfg_req.be[0])
                        st_nxt.addr_lo[5:0] = cfg_req.wdata[7:2];
                    if (cfg_req.be[1])
                        st_nxt.addr_lo[13:6] = cfg_req.wdata[15:8];
                    if (cfg_req.be[2])
                        st_nxt.addr_lo[21:14] = cfg_req.wdata[23:16];
                    if (cfg_req.be[3])
                        st_nxt.addr_lo[29:22] = cfg_req.wdata[31:24];
                end
                MCR_OFF_ADDR_HI:
                begin
                    for (int i = 0; i < 4; i++)
                        if (cfg_req.be[i])
                            st_nxt.addr_hi[i*8 +: 8] =
                                cfg_req.wdata[i*8 +: 8];
                end
                MCR_OFF_PAYLOAD:
                begin
                    for (int i = 0; i < 2; i++)
                        if (cfg_req.be[i])
                            st_nxt.payload[i*8 +: 8] =
                                cfg_req.wdata[i*8 +: 8];
                end
                default:
                    st_nxt.enable = st_r.enable;
            endcase
        end
        // Read mux; unmapped offsets read zero
        case (cfg_req.addr)
            MCR_OFF_CTRL_DW:
                st_nxt.rdata = {ctrl_word, MCR_NEXT_PTR, MCR_CAP_ID};
            MCR_OFF_ADDR_LO: st_nxt.rdata = addr_lo_word;
            MCR_OFF_ADDR_HI: st_nxt.rdata = st_r.addr_hi;
            MCR_OFF_PAYLOAD: st_nxt.rdata = {16'h0000, st_r.payload};
            default:         st_nxt.rdata = 32'h0000_0000;
        endcase
        // Message uses the registers as they stand before this cycle's write
        if (irq_event && st_r.enable)
        begin
            st_nxt.fixed_payload_bits.valid   = 1'b1;
            st_nxt.fixed_payload_bits.wide    = (st_r.addr_hi != MCR_ADDR_RESET);
            st_nxt.fixed_payload_bits.addr    = {st_r.addr_hi, addr_lo_word};
            st_nxt.fixed_payload_bits.payload = st_r.payload;
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r         <= '0;
            st_r.grant   <= MCR_GRANT_RESET;
            st_r.addr_lo <= MCR_ADDR_RESET[31:2];
            st_r.addr_hi <= MCR_ADDR_RESET;
            st_r.payload <= MCR_PAYLOAD_RESET;
        end
        else
            st_r <= st_nxt;
    end

    // Outputs straight from flip-flops
    assign cfg_rdata             = st_r.rdata;
    assign cfg_rvalid            = st_r.rvalid;
    assign msg_out               = st_r.fixed_payload_bits;
    assign signaling_enabled     = st_r.enable;
    assign granted_message_count = st_r.grant;

    // ========================================================
    // Checks
    // Event cycle with signaling on; the message follows one edge later
    sequence s_event_enabled;
        irq_event && st_r.enable;
    endsequence

    // Event cycle with signaling off; must be dropped, not remembered
    sequence s_event_disabled;
        irq_event && !st_r.enable;
    endsequence

    // Message launch: gating, address form and payload
    AST_NO_MSG_DISABLED: assert property (@(posedge core_clk)
        disable iff (!nrst)
        msg_out.valid |-> $past(st_r.enable))
        else $error("message sent while disabled");
    AST_EVENT_DROPPED: assert property (@(posedge core_clk)
        disable iff (!nrst)
        s_event_disabled |=> !msg_out.valid)
        else $error("event while disabled produced a message");
    AST_MSG_SENT: assert property (@(posedge core_clk)
        disable iff (!nrst)
        s_event_enabled |=> msg_out.valid)
        else $error("enabled event produced no message");
    AST_MSG_ADDR: assert property (@(posedge core_clk)
        disable iff (!nrst)
        s_event_enabled |=> msg_out.addr == {$past(st_r.addr_hi),
                                            $past(st_r.addr_lo),
                                            MCR_ADDR_RSVD})
        else $error("message target address wrong");
    AST_WIDE_FLAG: assert property (@(posedge core_clk)
        disable iff (!nrst)
        msg_out.valid |-> msg_out.wide == (msg_out.addr[63:32] != 32'h0))
        else $error("address width form wrong");
    AST_PAYLOAD: assert property (@(posedge core_clk)
        disable iff (!nrst)
        s_event_enabled |=> msg_out.payload == $past(st_r.payload))
        else $error("payload altered");
    AST_VECTOR: assert property (@(posedge core_clk)
        disable iff (!nrst)
        s_event_enabled |=> msg_out.payload[3:0] == $past(st_r.payload[3:0]))
        else $error("vector bits altered");

    // Read views of fixed and reserved fields
    AST_CAP_FLAG: assert property (@(posedge core_clk)
        disable iff (!nrst)
        cfg_rvalid && $past(cfg_req.addr) == MCR_OFF_CTRL_DW
        |-> cfg_rdata[23] && cfg_rdata[19:17] == 3'h0)
        else $error("capability or requested count wrong");
    AST_RSVD: assert property (@(posedge core_clk)
        disable iff (!nrst)
        cfg_rvalid && $past(cfg_req.addr) == MCR_OFF_ADDR_LO
        |-> cfg_rdata[1:0] == 2'h0)
        else $error("reserved address bits nonzero");
    AST_CTRL_RSVD: assert property (@(posedge core_clk)
        disable iff (!nrst)
        cfg_rvalid && $past(cfg_req.addr) == MCR_OFF_CTRL_DW
        |-> cfg_rdata[31:24] == 8'h0)
        else $error("reserved control bits nonzero");

    // Register writes land one edge after the strobe
    AST_GRANT: assert property (@(posedge core_clk)
        disable iff (!nrst)
        cfg_req.wr && cfg_req.addr == MCR_OFF_CTRL_DW && cfg_req.be[2]
        |=> granted_message_count == $past(cfg_req.wdata[22:20]))
        else $error("granted count not stored");
    // Only a control write with its lane enabled may move the count
    AST_GRANT_HOLD: assert property (@(posedge core_clk)
        disable iff (!nrst)
        !(cfg_req.wr && cfg_req.addr == MCR_OFF_CTRL_DW && cfg_req.be[2])
        |=> $stable(granted_message_count))
        else $error("granted count changed without a write");
    AST_LO_WRITE: assert property (@(posedge core_clk)
        disable iff (!nrst)
        cfg_req.wr && cfg_req.addr == MCR_OFF_ADDR_LO && cfg_req.be == 4'hF
        |=> addr_lo_word == {$past(cfg_req.wdata[31:2]), MCR_ADDR_RSVD})
        else $error("lower address not stored");
    AST_HI_WRITE: assert property (@(posedge core_clk)
        disable iff (!nrst)
        cfg_req.wr && cfg_req.addr == MCR_OFF_ADDR_HI && cfg_req.be == 4'hF
        |=> st_r.addr_hi == $past(cfg_req.wdata))
        else $error("upper address not stored");
    AST_PAYLOAD_WRITE: assert property (@(posedge core_clk)
        disable iff (!nrst)
        cfg_req.wr && cfg_req.addr == MCR_OFF_PAYLOAD
        && cfg_req.be[1:0] == 2'h3
        |=> st_r.payload == $past(cfg_req.wdata[15:0]))
        else $error("payload not stored");

    // Reset values; no disable here, since reset is what is checked
    AST_RESET_REGS: assert property (@(posedge core_clk)
        !nrst |=> st_r.addr_lo == MCR_ADDR_RESET[31:2]
            && st_r.addr_hi == MCR_ADDR_RESET
            && st_r.payload == MCR_PAYLOAD_RESET)
        else $error("address or payload not cleared by reset");
    AST_RESET_CTRL: assert property (@(posedge core_clk)
        !nrst |=> ctrl_word == MCR_CTRL_RESET)
        else $error("control word reset value wrong");

endmodule : mcr_msi_regs

// ---- mcr_host_sink.sv ----
/*
 * Host-side message sink: takes the posted writes sent upstream and keeps
 * a count and the last one received.
 * Assumes the link takes every pulse of msg_in.valid without back-pressure.
 */
`timescale 1ns/10ps

module mcr_host_sink
    import mcr_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire mcr_pkg::mcr_msg_s msg_in,
    output logic [7:0]             msg_count,
    output mcr_pkg::mcr_msg_s      last_msg
);
    // ========================================================
    // Capture; a real host acks nothing, so no answer is given
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            msg_count <= 8'h00;
            last_msg  <= '0;
        end
        else if (msg_in.valid)
        begin
            msg_count <= msg_count + 8'h01;
            last_msg  <= msg_in;
        end
    end
endmodule : mcr_host_sink

// ---- mcr_msi_regs_tb_top.sv ----
/*
 * Testbench: config reads and writes plus interrupt events, self-checked.
 * Assumes mcr_pkg and mcr_host_sink are compiled before this file.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module mcr_msi_regs_tb_top;
    import mcr_pkg::*;
    logic         core_clk  = 1'b0;
    logic         nrst      = 1'b0;
    mcr_cfg_req_s req       = '0;
    logic         irq       = 1'b0;
    logic [31:0]  rdata;
    logic         rvalid;
    mcr_msg_s     fixed_payload_bits;
    mcr_msg_s     last;
    logic         en;
    logic [2:0]   grant;
    logic [7:0]   n_msg;
    int           err_count = 0;
    int           checked   = 0;

    // ========================================================
    // Clock, design and host model
    always #4 core_clk = ~core_clk;

    mcr_msi_regs u_mcr_msi_regs (.core_clk(core_clk), .nrst(nrst),
        .cfg_req(req), .cfg_rdata(rdata), .cfg_rvalid(rvalid),
        .irq_event(irq), .msg_out(fixed_payload_bits), .signaling_enabled(en),
        .granted_message_count(grant));
    mcr_host_sink u_mcr_host_sink (.core_clk(core_clk), .nrst(nrst),
        .msg_in(fixed_payload_bits), .msg_count(n_msg), .last_msg(last));

    // ========================================================
    // Bus tasks; strobes last exactly one cycle
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b,
                          input logic [31:0] d);
        @(posedge core_clk);
        req <= '{rd:1'b0, wr:1'b1, addr:a, be:b, wdata:d};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : cfg_wr

    task automatic cfg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        req <= '{rd:1'b1, wr:1'b0, addr:a, be:4'h0, wdata:32'h0};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1;
        `CHK(rvalid, 1'b1)
        `CHK(rdata, e)
    endtask : cfg_rd

    // Valid is a one-cycle pulse, so look right after its edge
    task automatic fire(input logic e);
        @(posedge core_clk);
        irq <= 1'b1;
        @(posedge core_clk);
        irq <= 1'b0;
        #1;
        `CHK(fixed_payload_bits.valid, e)
    endtask : fire

    task automatic complete_run();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // ========================================================
    // Test sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        cfg_rd(MCR_OFF_CTRL_DW, 32'h0080_8005);
        cfg_rd(MCR_OFF_ADDR_LO, 32'h0);
        cfg_rd(MCR_OFF_ADDR_HI, 32'h0);
        cfg_rd(MCR_OFF_PAYLOAD, 32'h0);
        cfg_rd(8'h40, 32'h0);
        fire(1'b0);
        cfg_wr(MCR_OFF_CTRL_DW, 4'hF, 32'hFFFF_FFFF);
        cfg_rd(MCR_OFF_CTRL_DW, 32'h00F1_8005);
        // Grant codes 0 to 5; each write keeps signaling enabled
        for (int c = 0; c < 6; c++)
        begin
            cfg_wr(MCR_OFF_CTRL_DW, 4'h4, {9'h0, 3'(c), 4'h1, 16'h0});
            #1;
            `CHK(grant, 3'(c))
        end
        `CHK(en, 1'b1)
        cfg_wr(MCR_OFF_ADDR_LO, 4'hF, 32'hFFFF_FFFF);
        cfg_rd(MCR_OFF_ADDR_LO, 32'hFFFF_FFFC);
        cfg_wr(MCR_OFF_ADDR_LO, 4'hF, 32'h1234_5678);
        cfg_wr(MCR_OFF_PAYLOAD, 4'hF, 32'hFFFF_A5C3);
        cfg_rd(MCR_OFF_PAYLOAD, 32'h0000_A5C3);
        fire(1'b1);
        `CHK(fixed_payload_bits.wide, 1'b0)
        `CHK(fixed_payload_bits.addr, 64'h0000_0000_1234_5678)
        `CHK(fixed_payload_bits.payload, 16'hA5C3)
        cfg_wr(MCR_OFF_ADDR_HI, 4'hF, 32'h8000_0001);
        cfg_rd(MCR_OFF_ADDR_HI, 32'h8000_0001);
        fire(1'b1);
        `CHK(fixed_payload_bits.wide, 1'b1)
        // Disable, but leave a nonzero grant for the reset check below
        cfg_wr(MCR_OFF_CTRL_DW, 4'h4, 32'h0030_0000);
        fire(1'b0);
        `CHK(n_msg, 8'h02)
        `CHK(last.addr, 64'h8000_0001_1234_5678)
        // Reset again mid-run; programmed values must be wiped
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        cfg_rd(MCR_OFF_ADDR_HI, 32'h0);
        cfg_rd(MCR_OFF_PAYLOAD, 32'h0);
        cfg_rd(MCR_OFF_CTRL_DW, 32'h0080_8005);
        complete_run();
    end

    // Sequence needs about 75 cycles; 2500 means a hang
    initial
    begin
        #20000;
        err_count++;
        complete_run();
    end
endmodule : mcr_msi_regs_tb_top
